// ==== design/dmairq_top.sv ====
// Interrupt flags, enables, start addresses and sizes of one DMA channel.
`timescale 1ns/10ps
`include "dmairq_defs.svh"

// Notes on behaviour
// R1: Source-done flag sets when the source pointer reaches the source size.
// R2: Source-half flag sets when the source pointer equals half the source size.
// R3: Destination-done flag sets when the destination pointer reaches the destination size.
// R4: Destination-half flag sets when the destination pointer equals half its size.
// R5: Block-done flag sets when the larger size has moved, or on pattern match.
// R6: Cell-done flag sets each time a whole cell has been transferred.
// R7: A system interrupt matching the abort selection aborts and sets the abort flag.
// R8: Address-error flag sets when source or destination address is invalid.
// R9: Eight enables in bits 23..16 mirror the flags; reset to zero.
// R10: Flags are read/write, reset to zero; software clears one by writing zero.
// R11: Software loads a physical source start address; resets to zero.
// R12: Software loads a physical destination start address; resets to zero.
// R13: Source size zero means 65,536 bytes, otherwise its value.
// R14: Unimplemented bits of interrupt and size registers read as zero.
// R15: Destination size zero means 65,536 bytes, otherwise its value.
// R16: A read-only 16-bit source pointer counts from byte 0.
// R17: Interrupt numbers 0..255 compare against the 8-bit abort selection.
// R18: Interrupt request is high while any flag and its enable are both set.
module dmairq_top #(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_ce,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output      logic [31:0]       o_rdata,
    // Transfer engine strobes
    input  wire logic              i_restart,
    input  wire logic              i_src_step,
    input  wire logic              i_dst_step,
    input  wire logic              i_pattern_match,
    input  wire logic              i_cell_done,
    input  wire logic              i_addr_err,
    // System interrupt numbers
    input  wire logic              i_irq_valid,
    input  wire logic [7:0]        i_irq_num,
    // Results
    output      logic [31:0]       o_src_start_addr,
    output      logic [31:0]       o_dst_start_addr,
    output      logic              o_abort,
    output      logic              o_irq
);

    generate
        if (ADDR_W < 5 || ADDR_W > 16) begin : g_bad_addr_w
            $error("ADDR_W must lie between 5 and 16");
        end
    endgenerate

    dmairq_pkg::dmairq_regs_t r_r;
    dmairq_pkg::dmairq_regs_t r_nxt;
    logic [7:0]               sel;
    dmairq_evt_if             evt ();

    // Decodes the register port address into a one-hot register select.
    function automatic logic [7:0] decode(input logic [ADDR_W-1:0] a);
        logic [7:0] full;
        full   = 8'(a);
        decode = 8'h00;
        if (a[ADDR_W-1:0] == ADDR_W'(full)) begin
            case (full)
                `DMAIRQ_OFS_INT:       decode = 8'h01;
                `DMAIRQ_OFS_SSA:       decode = 8'h02;
                `DMAIRQ_OFS_DSA:       decode = 8'h04;
                `DMAIRQ_OFS_SSIZ:      decode = 8'h08;
                `DMAIRQ_OFS_DSIZ:      decode = 8'h10;
                `DMAIRQ_OFS_ABORT_SEL: decode = 8'h20;
                `DMAIRQ_OFS_SPTR:      decode = 8'h40;
                `DMAIRQ_OFS_DPTR:      decode = 8'h80;
                default:               decode = 8'h00;
            endcase
        end
        if (ADDR_W > 8) begin
            if ((a >> 8) != '0) begin
                decode = 8'h00;
            end
        end
    endfunction

    dmairq_evt_unit u_evt (
        .i_clk           (i_clk),
        .i_rst_b         (i_rst_b),
        .i_ce            (i_ce),
        .i_restart       (i_restart),
        .i_src_step      (i_src_step),
        .i_dst_step      (i_dst_step),
        .i_pattern_match (i_pattern_match),
        .i_cell_done     (i_cell_done),
        .i_addr_err      (i_addr_err),
        .i_irq_valid     (i_irq_valid),
        .i_irq_num       (i_irq_num),
        .evt             (evt.unit)
    );

    assign evt.src_size  = r_r.ssiz;
    assign evt.dst_size  = r_r.dsiz;
    assign evt.abort_sel = r_r.abort_sel;

    always_comb begin
        r_nxt = r_r;
        sel   = decode(i_addr);
        if (i_wr) begin
            if (sel[0]) begin
                // R9: enables written
                r_nxt.en   = i_wdata[`DMAIRQ_EN_LSB +: 8];
                // R10: software writes flags
                r_nxt.flag = i_wdata[7:0];
            end
            // R11: source start address
            if (sel[1]) begin
                r_nxt.ssa = i_wdata;
            end
            // R12: destination start address
            if (sel[2]) begin
                r_nxt.dsa = i_wdata;
            end
            if (sel[3]) begin
                r_nxt.ssiz = i_wdata[15:0];
            end
            if (sel[4]) begin
                r_nxt.dsiz = i_wdata[15:0];
            end
            if (sel[5]) begin
                r_nxt.abort_sel = i_wdata[7:0];
            end
        end
        // R1: hardware set wins over a same-cycle clear
        r_nxt.flag = r_nxt.flag | evt.ev;
        // R7: abort the transfer
        r_nxt.abort = evt.ev[`DMAIRQ_BIT_ABORT];
        // R18: unmasked flag drives request
        r_nxt.irq = |(r_nxt.flag & r_nxt.en);
        // Read data stands only in the cycle after the read strobe, zero otherwise.
        r_nxt.rdata = 32'h00000000;
        if (i_rd) begin
            // R14: unimplemented bits read zero
            case (sel)
                8'h01:   r_nxt.rdata = {8'h00, r_r.en, 8'h00, r_r.flag};
                8'h02:   r_nxt.rdata = r_r.ssa;
                8'h04:   r_nxt.rdata = r_r.dsa;
                8'h08:   r_nxt.rdata = {16'h0000, r_r.ssiz};
                8'h10:   r_nxt.rdata = {16'h0000, r_r.dsiz};
                8'h20:   r_nxt.rdata = {24'h000000, r_r.abort_sel};
                // R16: source pointer read-only
                8'h40:   r_nxt.rdata = {16'h0000, evt.src_byte_ptr};
                8'h80:   r_nxt.rdata = {16'h0000, evt.dst_byte_ptr};
                default: r_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            r_r.flag      <= `DMAIRQ_FLAG_RST;
            r_r.en        <= `DMAIRQ_EN_RST;
            r_r.ssa       <= `DMAIRQ_ADDR_RST;
            r_r.dsa       <= `DMAIRQ_ADDR_RST;
            r_r.ssiz      <= `DMAIRQ_SIZE_RST;
            r_r.dsiz      <= `DMAIRQ_SIZE_RST;
            r_r.abort_sel <= `DMAIRQ_ABORT_SEL_RST;
            r_r.rdata     <= 32'h00000000;
            r_r.irq       <= 1'b0;
            r_r.abort     <= 1'b0;
        end else if (i_ce) begin
            r_r <= r_nxt;
        end
    end

    assign o_rdata          = r_r.rdata;
    assign o_src_start_addr = r_r.ssa;
    assign o_dst_start_addr = r_r.dsa;
    assign o_abort          = r_r.abort;
    assign o_irq            = r_r.irq;

endmodule

// ==== design/dmairq_defs.svh ====
// Register offsets, field positions and reset values of the DMA channel interrupt and address slice.
`ifndef DMAIRQ_DEFS_SVH
`define DMAIRQ_DEFS_SVH

`define DMAIRQ_OFS_INT        8'h00
`define DMAIRQ_OFS_SSA        8'h04
`define DMAIRQ_OFS_DSA        8'h08
`define DMAIRQ_OFS_SSIZ       8'h0C
`define DMAIRQ_OFS_DSIZ       8'h10
`define DMAIRQ_OFS_ABORT_SEL  8'h14
`define DMAIRQ_OFS_SPTR       8'h18
`define DMAIRQ_OFS_DPTR       8'h1C

`define DMAIRQ_BIT_SRC_DONE   7
`define DMAIRQ_BIT_SRC_HALF   6
`define DMAIRQ_BIT_DST_DONE   5
`define DMAIRQ_BIT_DST_HALF   4
`define DMAIRQ_BIT_BLOCK_DONE 3
`define DMAIRQ_BIT_CELL_DONE  2
`define DMAIRQ_BIT_ABORT      1
`define DMAIRQ_BIT_ADDR_ERR   0
`define DMAIRQ_EN_LSB         16

`define DMAIRQ_FLAG_RST       8'h00
`define DMAIRQ_EN_RST         8'h00
`define DMAIRQ_ADDR_RST       32'h00000000
`define DMAIRQ_SIZE_RST       16'h0000
`define DMAIRQ_PTR_RST        16'h0000
`define DMAIRQ_ABORT_SEL_RST  8'hFF

`endif

// ==== design/dmairq_pkg.sv ====
// Types shared by the DMA channel interrupt and address slice.
package dmairq_pkg;

    // Register and interrupt state of the top module.
    typedef struct packed {
        logic [7:0]  flag;
        logic [7:0]  en;
        logic [31:0] ssa;
        logic [31:0] dsa;
        logic [15:0] ssiz;
        logic [15:0] dsiz;
        logic [7:0]  abort_sel;
        logic [31:0] rdata;
        logic        irq;
        logic        abort;
    } dmairq_regs_t;

    // Pointer and event state of the event unit.
    typedef struct packed {
        logic [15:0] sptr;
        logic [15:0] dptr;
        logic [7:0]  ev;
    } dmairq_evst_t;

endpackage

// ==== design/dmairq_evt_if.sv ====
// Carrier between the register file and the event unit of the DMA channel slice.
`timescale 1ns/10ps
interface dmairq_evt_if;
    logic [15:0] src_size;
    logic [15:0] dst_size;
    logic [7:0]  abort_sel;
    logic [15:0] src_byte_ptr;
    logic [15:0] dst_byte_ptr;
    logic [7:0]  ev;

    modport regs (output src_size, output dst_size, output abort_sel,
                  input src_byte_ptr, input dst_byte_ptr, input ev);
    modport unit (input src_size, input dst_size, input abort_sel,
                  output src_byte_ptr, output dst_byte_ptr, output ev);
endinterface

// ==== design/dmairq_evt_unit.sv ====
// Byte pointers and event detection of one DMA channel.
`timescale 1ns/10ps
`include "dmairq_defs.svh"
module dmairq_evt_unit (
    // Clock, reset, enable
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_ce,
    // Transfer engine strobes
    input  wire logic       i_restart,
    input  wire logic       i_src_step,
    input  wire logic       i_dst_step,
    input  wire logic       i_pattern_match,
    input  wire logic       i_cell_done,
    input  wire logic       i_addr_err,
    // System interrupt numbers
    input  wire logic       i_irq_valid,
    input  wire logic [7:0] i_irq_num,
    // Register side
    dmairq_evt_if.unit      evt
);

    dmairq_pkg::dmairq_evst_t s_r;
    dmairq_pkg::dmairq_evst_t s_nxt;
    logic [16:0]              src_eff;
    logic [16:0]              dst_eff;
    logic [16:0]              src_adv;
    logic [16:0]              dst_adv;

    // A zero size field stands for the full 65,536 bytes, hence the extra bit.
    function automatic logic [16:0] size_eff(input logic [15:0] sz);
        size_eff = {(sz == 16'h0000), sz};
    endfunction

    function automatic logic [16:0] advance(input logic [15:0] p);
        advance = {1'b0, p} + 17'h00001;
    endfunction

    always_comb begin
        s_nxt    = s_r;
        s_nxt.ev = 8'h00;
        // R13: zero means full size
        src_eff  = size_eff(evt.src_size);
        // R15: zero means full size
        dst_eff  = size_eff(evt.dst_size);
        src_adv  = advance(s_r.sptr);
        dst_adv  = advance(s_r.dptr);
        if (i_src_step) begin
            // R16: source pointer advance
            s_nxt.sptr = src_adv[15:0];
            // R1: source end reached
            if (src_adv == src_eff) begin
                s_nxt.ev[`DMAIRQ_BIT_SRC_DONE] = 1'b1;
                s_nxt.sptr                     = `DMAIRQ_PTR_RST;
                // R5: larger side finished
                if (src_eff >= dst_eff) begin
                    s_nxt.ev[`DMAIRQ_BIT_BLOCK_DONE] = 1'b1;
                end
            end
            // R2: source midpoint
            if (src_adv == {1'b0, src_eff[16:1]}) begin
                s_nxt.ev[`DMAIRQ_BIT_SRC_HALF] = 1'b1;
            end
        end
        if (i_dst_step) begin
            s_nxt.dptr = dst_adv[15:0];
            // R3: destination end reached
            if (dst_adv == dst_eff) begin
                s_nxt.ev[`DMAIRQ_BIT_DST_DONE] = 1'b1;
                s_nxt.dptr                     = `DMAIRQ_PTR_RST;
                // R5: larger side finished
                if (dst_eff > src_eff) begin
                    s_nxt.ev[`DMAIRQ_BIT_BLOCK_DONE] = 1'b1;
                end
            end
            // R4: destination midpoint
            if (dst_adv == {1'b0, dst_eff[16:1]}) begin
                s_nxt.ev[`DMAIRQ_BIT_DST_HALF] = 1'b1;
            end
        end
        // R5: pattern match ends block
        if (i_pattern_match) begin
            s_nxt.ev[`DMAIRQ_BIT_BLOCK_DONE] = 1'b1;
            s_nxt.sptr                       = `DMAIRQ_PTR_RST;
        end
        // R6: cell finished
        s_nxt.ev[`DMAIRQ_BIT_CELL_DONE] = i_cell_done;
        // R8: address error seen
        s_nxt.ev[`DMAIRQ_BIT_ADDR_ERR]  = i_addr_err;
        // R17: abort number compare
        s_nxt.ev[`DMAIRQ_BIT_ABORT]     = i_irq_valid && (i_irq_num == evt.abort_sel);
        // A restart wins over a step in the same cycle: the new block begins at byte 0.
        if (i_restart) begin
            s_nxt.sptr = `DMAIRQ_PTR_RST;
            s_nxt.dptr = `DMAIRQ_PTR_RST;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            s_r.sptr <= `DMAIRQ_PTR_RST;
            s_r.dptr <= `DMAIRQ_PTR_RST;
            s_r.ev   <= 8'h00;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    assign evt.src_byte_ptr = s_r.sptr;
    assign evt.dst_byte_ptr = s_r.dptr;
    assign evt.ev           = s_r.ev;

endmodule

// ==== verif/dmairq_sva.sv ====
// Port-level checks of the DMA channel interrupt and address slice.
`timescale 1ns/10ps
`include "dmairq_defs.svh"
module dmairq_sva #(
    parameter int ADDR_W = 8
) (
    // Clock, reset and enable
    input wire logic              i_clk,
    input wire logic              i_rst_b,
    input wire logic              i_ce,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0]       i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [31:0]       o_rdata,
    // Events and results
    input wire logic              i_irq_valid,
    input wire logic [31:0]       o_src_start_addr,
    input wire logic [31:0]       o_dst_start_addr,
    input wire logic              o_abort,
    input wire logic              o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic wr_int;
    logic wr_ssa;
    logic wr_dsa;
    assign wr_int = i_ce && i_wr && i_addr == ADDR_W'(`DMAIRQ_OFS_INT);
    assign wr_ssa = i_ce && i_wr && i_addr == ADDR_W'(`DMAIRQ_OFS_SSA);
    assign wr_dsa = i_ce && i_wr && i_addr == ADDR_W'(`DMAIRQ_OFS_DSA);
    sequence s_quiet_irq;
        i_ce && !i_irq_valid ##1 i_ce;
    endsequence
    sequence s_rd_size;
        i_ce && i_rd && i_addr == ADDR_W'(`DMAIRQ_OFS_SSIZ);
    endsequence
    a_rst_clears_all: assert property (disable iff (1'b0) !i_rst_b |=>
        !o_irq && !o_abort && o_rdata == 32'h0 && o_src_start_addr == 32'h0 && o_dst_start_addr == 32'h0)
        else $error("outputs not cleared by reset");
    a_ssa_load: assert property (wr_ssa ##1 !wr_ssa |=> o_src_start_addr == $past(i_wdata, 2))
        else $error("source start address not loaded");
    a_dsa_load: assert property (wr_dsa ##1 !wr_dsa |=> o_dst_start_addr == $past(i_wdata, 2))
        else $error("destination start address not loaded");
    a_ssa_hold: assert property (!wr_ssa ##1 !wr_ssa |=> $stable(o_src_start_addr))
        else $error("source start address changed without a write");
    a_irq_masked: assert property (wr_int && i_wdata[23:16] == 8'h00 |=> !o_irq)
        else $error("interrupt raised with all enables clear");
    a_irq_raise: assert property (wr_int && (i_wdata[23:16] & i_wdata[7:0]) != 8'h00 |=> o_irq)
        else $error("interrupt missing for enabled flag");
    a_abort_quiet: assert property (s_quiet_irq |=> !o_abort)
        else $error("abort without a matching interrupt");
    a_int_gaps_zero: assert property (i_ce && i_rd && i_addr == ADDR_W'(`DMAIRQ_OFS_INT) |=>
        o_rdata[31:24] == 8'h00 && o_rdata[15:8] == 8'h00)
        else $error("unimplemented interrupt bits read nonzero");
    a_size_high_zero: assert property (s_rd_size |=> o_rdata[31:16] == 16'h0000)
        else $error("unimplemented size bits read nonzero");
endmodule

// ==== verif/dmairq_engine_model.sv ====
// Transfer engine stand-in that issues source and destination byte steps.
`timescale 1ns/10ps
module dmairq_engine_model (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // Command from the bench
    input  wire logic        i_start,
    input  wire logic [1:0]  i_which,
    input  wire logic        i_slow,
    input  wire logic [16:0] i_count,
    // Strobes to the channel
    output      logic        o_src_step,
    output      logic        o_dst_step,
    output      logic        o_busy
);
    logic [16:0] left_r;
    logic [1:0]  which_r;
    logic        slow_r;
    logic        gap_r;
    logic        fire;
    // A slow engine idles a cycle after each byte, as a stalled bus would.
    assign fire = left_r != 17'h0 && !gap_r;
    assign o_busy = left_r != 17'h0;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            left_r <= 17'h0;
            which_r <= 2'h0;
            slow_r <= 1'b0;
            gap_r <= 1'b0;
        end else if (i_start) begin
            left_r <= i_count;
            which_r <= i_which;
            slow_r <= i_slow;
            gap_r <= 1'b0;
        end else if (fire) begin
            left_r <= left_r - 17'h1;
            gap_r <= slow_r;
        end else begin
            gap_r <= 1'b0;
        end
        o_src_step <= i_rst_b && fire && which_r[0];
        o_dst_step <= i_rst_b && fire && which_r[1];
    end
endmodule

// ==== verif/dma_channel_irq_addr_size_tb_top.sv ====
// Register-level testbench of the DMA channel interrupt and address slice.
`timescale 1ns/10ps
`include "dmairq_defs.svh"
module dma_channel_irq_addr_size_tb_top;
    logic        i_clk;
    logic        i_rst_b;
    logic        i_ce;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic        i_restart;
    logic [2:0]  ev;
    logic        i_irq_valid;
    logic [7:0]  i_irq_num;
    logic        eng_start;
    logic        eng_slow;
    logic [1:0]  eng_which;
    logic [16:0] eng_count;
    logic        src_step;
    logic        dst_step;
    logic        eng_busy;
    logic [31:0] o_rdata;
    logic [31:0] o_ssa;
    logic [31:0] o_dsa;
    logic        o_abort;
    logic        o_irq;
    int          n_mismatch;
    int          comparisons;
    int          n_abort;

    dmairq_top #(.ADDR_W(8)) dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_restart(i_restart),
        .i_src_step(src_step), .i_dst_step(dst_step), .i_pattern_match(ev[2]),
        .i_cell_done(ev[1]), .i_addr_err(ev[0]), .i_irq_valid(i_irq_valid),
        .i_irq_num(i_irq_num), .o_src_start_addr(o_ssa), .o_dst_start_addr(o_dsa),
        .o_abort(o_abort), .o_irq(o_irq));
    dmairq_engine_model eng (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(eng_start), .i_which(eng_which),
        .i_slow(eng_slow), .i_count(eng_count), .o_src_step(src_step),
        .o_dst_step(dst_step), .o_busy(eng_busy));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) if (o_abort === 1'b1) n_abort++;

    task close_out;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Each access ends with an idle cycle so no strobe is driven twice in one step.
    task wr(input logic [7:0] a, input logic [31:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
        @(posedge i_clk);
    endtask
    task run(input logic [1:0] w, input logic [16:0] n, input logic s);
        eng_which <= w;
        eng_count <= n;
        eng_slow <= s;
        eng_start <= 1'b1;
        @(posedge i_clk);
        eng_start <= 1'b0;
        @(posedge i_clk);
        // The longest run moves 32,768 bytes, so this bound only trips on a hang.
        for (int i = 0; i < 40000 && eng_busy; i++) @(posedge i_clk);
        if (eng_busy !== 1'b0) begin
            n_mismatch++;
            close_out();
        end
        repeat (4) @(posedge i_clk);
    endtask
    task pulse_restart;
        i_restart <= 1'b1;
        @(posedge i_clk);
        i_restart <= 1'b0;
        @(posedge i_clk);
    endtask

    initial begin
        {i_rst_b, i_wr, i_rd, i_restart, ev, i_irq_valid, eng_start, eng_slow} <= '0;
        {i_addr, i_wdata, i_irq_num, eng_which, eng_count} <= '0;
        i_ce <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        for (int k = 0; k < 8; k++) rd_chk(8'(4 * k), k == 5 ? 32'h000000FF : 32'h0);
        wr(`DMAIRQ_OFS_SSA, 32'hA5C31E87);
        wr(`DMAIRQ_OFS_DSA, 32'h5A3CE178);
        chk(o_ssa, 32'hA5C31E87);
        chk(o_dsa, 32'h5A3CE178);
        rd_chk(`DMAIRQ_OFS_DSA, 32'h5A3CE178);
        wr(`DMAIRQ_OFS_SSIZ, 32'hFFFF0004);
        rd_chk(`DMAIRQ_OFS_SSIZ, 32'h00000004);
        wr(`DMAIRQ_OFS_INT, 32'hFFFFFFFF);
        rd_chk(`DMAIRQ_OFS_INT, 32'h00FF00FF);
        chk({31'h0, o_irq}, 32'h1);
        wr(`DMAIRQ_OFS_INT, 32'h00FF0000);
        rd_chk(`DMAIRQ_OFS_INT, 32'h00FF0000);
        chk({31'h0, o_irq}, 32'h0);
        wr(`DMAIRQ_OFS_SPTR, 32'h00001234);
        rd_chk(`DMAIRQ_OFS_SPTR, 32'h0);
        rd_chk(8'h20, 32'h0);
        wr(`DMAIRQ_OFS_INT, 32'h00800000);
        wr(`DMAIRQ_OFS_DSIZ, 32'h00000008);
        run(2'b01, 17'h3, 1'b1);
        rd_chk(`DMAIRQ_OFS_SPTR, 32'h3);
        rd_chk(`DMAIRQ_OFS_INT, 32'h00800040);
        chk({31'h0, o_irq}, 32'h0);
        run(2'b01, 17'h1, 1'b0);
        rd_chk(`DMAIRQ_OFS_SPTR, 32'h0);
        rd_chk(`DMAIRQ_OFS_INT, 32'h008000C0);
        chk({31'h0, o_irq}, 32'h1);
        run(2'b10, 17'h8, 1'b0);
        rd_chk(`DMAIRQ_OFS_INT, 32'h008000F8);
        // The destination pointer wraps to byte 0 once the destination is done.
        rd_chk(`DMAIRQ_OFS_DPTR, 32'h0);
        run(2'b01, 17'h2, 1'b0);
        pulse_restart();
        rd_chk(`DMAIRQ_OFS_SPTR, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wr(`DMAIRQ_OFS_INT, 32'h0);
            ev <= 3'(1 << k);
            @(posedge i_clk);
            ev <= 3'b000;
            repeat (3) @(posedge i_clk);
            rd_chk(`DMAIRQ_OFS_INT, k == 2 ? 32'h8 : (k == 1 ? 32'h4 : 32'h1));
        end
        wr(`DMAIRQ_OFS_INT, 32'h0);
        wr(`DMAIRQ_OFS_ABORT_SEL, 32'h0000002A);
        for (int k = 0; k < 2; k++) begin
            i_irq_valid <= 1'b1;
            i_irq_num <= 8'h2B - 8'(k);
            @(posedge i_clk);
            i_irq_valid <= 1'b0;
            repeat (3) @(posedge i_clk);
            rd_chk(`DMAIRQ_OFS_INT, k == 1 ? 32'h2 : 32'h0);
        end
        chk(32'(n_abort), 32'h1);
        wr(`DMAIRQ_OFS_INT, 32'h0);
        wr(`DMAIRQ_OFS_SSIZ, 32'h0);
        wr(`DMAIRQ_OFS_DSIZ, 32'h0);
        run(2'b11, 17'h7FFF, 1'b0);
        rd_chk(`DMAIRQ_OFS_INT, 32'h0);
        run(2'b11, 17'h1, 1'b0);
        rd_chk(`DMAIRQ_OFS_INT, 32'h50);
        run(2'b11, 17'h8000, 1'b0);
        rd_chk(`DMAIRQ_OFS_INT, 32'hF8);
        // A write while the clock enable is low must not land.
        i_ce <= 1'b0;
        wr(`DMAIRQ_OFS_SSA, 32'h0F0F0F0F);
        i_ce <= 1'b1;
        chk(o_ssa, 32'hA5C31E87);
        rd_chk(`DMAIRQ_OFS_SSA, 32'hA5C31E87);
        // A second reset after the runs brings SSA, DSA, INT and ABORT_SEL back to their reset values.
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        rd_chk(`DMAIRQ_OFS_SSA, 32'h0);
        rd_chk(`DMAIRQ_OFS_DSA, 32'h0);
        rd_chk(`DMAIRQ_OFS_INT, 32'h0);
        rd_chk(`DMAIRQ_OFS_ABORT_SEL, 32'h000000FF);
        chk({31'h0, o_irq}, 32'h0);
        close_out();
    end
endmodule

bind dmairq_top dmairq_sva #(.ADDR_W(ADDR_W)) u_sva (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_valid(i_irq_valid),
    .o_src_start_addr(o_src_start_addr), .o_dst_start_addr(o_dst_start_addr),
    .o_abort(o_abort), .o_irq(o_irq));
